/* rtl/flash_host_pkg.sv */
// package: constants, types and rule overview for the parallel flash host controller
// Overview of operation
// - read: chip select, output enable low
// - write: write enable, chip select low
// - bypass program uses two write cycles
// - wait chip-select access after standby
package flash_host_pkg;

   // *****************************************
   // widths
   // *****************************************
   localparam int ADDR_W = 21;          // byte address width
   localparam int DATA_W = 8;           // data bus width

   // *****************************************
   // timing, in ns, and derived cycle counts
   // *****************************************
   localparam int CLK_NS       = 20;    // clock period
   localparam int ACC_NS       = 70;    // address access time, default speed grade
   localparam int CE_ACC_NS    = 70;    // chip-select access time
   localparam int WP_NS        = 35;    // write pulse width
   localparam int WPH_NS       = 30;    // write pulse high time
   localparam int RP_NS        = 500;   // reset pulse width
   localparam int RH_NS        = 50;    // reset high before read
   localparam int ACC_CYC      = (ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int CE_ACC_CYC   = (CE_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WP_CYC       = (WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WPH_CYC      = (WPH_NS + CLK_NS - 1) / CLK_NS;
   localparam int RP_CYC       = (RP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RH_CYC       = (RH_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W        = 8;     // phase counter width

   // *****************************************
   // command cycle constants
   // *****************************************
   localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 21'h000AAA; // first unlock address
   localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 21'h000555; // second unlock address
   localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 8'hAA;
   localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 8'h55;
   localparam logic [DATA_W-1:0] CMD_PROGRAM  = 8'hA0;
   localparam logic [DATA_W-1:0] CMD_ERASE    = 8'h80;
   localparam logic [DATA_W-1:0] CMD_CHIP_ER  = 8'h10;
   localparam logic [DATA_W-1:0] CMD_SECT_ER  = 8'h30;
   localparam logic [DATA_W-1:0] CMD_AUTOSEL  = 8'h90;
   localparam logic [DATA_W-1:0] CMD_BYPASS   = 8'h20;
   localparam logic [DATA_W-1:0] CMD_BYP_EX1  = 8'h90;
   localparam logic [DATA_W-1:0] CMD_BYP_EX2  = 8'h00;
   localparam logic [DATA_W-1:0] CMD_RESET    = 8'hF0;

   // *****************************************
   // host request kinds
   // *****************************************
   typedef enum logic [2:0] {
      OP_READ,        // one read cycle
      OP_WRITE,       // one raw write cycle
      OP_PROGRAM,     // full program sequence
      OP_SECT_ERASE,  // sector erase, more sectors may follow
      OP_CHIP_ERASE,  // whole array erase
      OP_AUTOSELECT,  // enter identification mode
      OP_BYPASS,      // enter or leave unlock bypass
      OP_RESET_PIN    // pulse the reset pin
   } op_t;

   // request carried in one struct
   typedef struct packed {
      op_t               op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } req_t;

   // flash pin bundle driven by the host
   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic              reset_n;
      logic [ADDR_W-1:0] byte_address;
      logic [DATA_W-1:0] data_bus_out;
      logic              data_bus_oe;
   } pins_t;

endpackage

/* rtl/flash_bus_cycle.sv */
// module: one timed bus cycle on the flash pins (read, write or reset pulse)
`timescale 1ns/1ps
module flash_bus_cycle (
   input  wire logic                                clk_i,
   input  wire logic                                rst_i,
   input  wire logic                                start_i,     // launch one cycle
   input  wire logic [1:0]                          kind_i,      // 0 read 1 write 2 reset
   input  wire logic [flash_host_pkg::ADDR_W-1:0]   addr_i,
   input  wire logic [flash_host_pkg::DATA_W-1:0]   data_i,
   input  wire logic [flash_host_pkg::DATA_W-1:0]   data_in_i,   // synchronised data bus
   input  wire logic                                standby_i,   // chip was deselected
   output flash_host_pkg::pins_t                    pins_o,
   output logic [flash_host_pkg::DATA_W-1:0]        rdata_o,
   output logic                                     done_o
);

   // *****************************************
   // phase machine
   // *****************************************
   typedef enum logic [1:0] {CY_IDLE, CY_ACT, CY_REC} cy_state_t;

   cy_state_t                               state_reg, state_next;   // phase
   logic [flash_host_pkg::CNT_W-1:0]        cnt_reg, cnt_next;       // phase counter
   logic [1:0]                              kind_reg;                // latched kind
   flash_host_pkg::pins_t                   pins_reg, pins_next;     // registered pins
   logic [flash_host_pkg::DATA_W-1:0]       rdata_reg;               // captured read data
   logic                                    done_reg;                // completion pulse

   // named decodes
   wire  is_rd  = (kind_i == 2'h0);
   wire  is_wr  = (kind_i == 2'h1);
   wire  k_rd   = (kind_reg == 2'h0);
   wire  k_wr   = (kind_reg == 2'h1);
   wire  cnt_z  = (cnt_reg == '0);
   // read wait: chip-select access after standby, else address access, plus sync delay
   wire  [flash_host_pkg::CNT_W-1:0] rd_wait = standby_i ?
         flash_host_pkg::CNT_W'(flash_host_pkg::CE_ACC_CYC + 2) :
         flash_host_pkg::CNT_W'(flash_host_pkg::ACC_CYC + 2);
   wire  [flash_host_pkg::CNT_W-1:0] act_len = is_rd ? rd_wait :
         (is_wr ? flash_host_pkg::CNT_W'(flash_host_pkg::WP_CYC) :
                  flash_host_pkg::CNT_W'(flash_host_pkg::RP_CYC));
   wire  [flash_host_pkg::CNT_W-1:0] rec_len = k_wr ?
         flash_host_pkg::CNT_W'(flash_host_pkg::WPH_CYC) :
         (k_rd ? flash_host_pkg::CNT_W'(1) : flash_host_pkg::CNT_W'(flash_host_pkg::RH_CYC));

   // next-state and pin logic
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_z ? cnt_reg : cnt_reg - 1'b1;
      pins_next  = pins_reg;
      case (state_reg)
         CY_IDLE: begin
            if (start_i) begin
               state_next              = CY_ACT;
               cnt_next                = act_len;
               pins_next.byte_address  = addr_i;
               pins_next.data_bus_out  = data_i;
               pins_next.ce_n          = is_rd | is_wr ? 1'b0 : 1'b1;
               pins_next.oe_n          = ~is_rd;
               pins_next.we_n          = ~is_wr;
               pins_next.data_bus_oe   = is_wr;
               pins_next.reset_n       = is_rd | is_wr;
            end
         end
         CY_ACT: begin
            if (cnt_z) begin
               // address taken on falling edge, data on rising edge
               state_next        = CY_REC;
               cnt_next          = rec_len;
               pins_next.ce_n    = 1'b1;
               pins_next.oe_n    = 1'b1;
               pins_next.we_n    = 1'b1;
               pins_next.reset_n = 1'b1;
            end
         end
         CY_REC: begin
            pins_next.data_bus_oe = 1'b0;                 // hold data one cycle past rise
            if (cnt_z) begin
               state_next = CY_IDLE;
            end
         end
         default: state_next = CY_IDLE;
      endcase
   end

   // registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= CY_IDLE;
         cnt_reg   <= '0;
         kind_reg  <= 2'h0;
         pins_reg  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1,
                        byte_address: '0, data_bus_out: '0, data_bus_oe: 1'b0};
         rdata_reg <= '0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         pins_reg  <= pins_next;
         if (state_reg == CY_IDLE && start_i) begin
            kind_reg <= kind_i;
         end
         if (state_reg == CY_ACT && cnt_z && k_rd) begin
            rdata_reg <= data_in_i;
         end
         done_reg <= (state_reg == CY_REC) && cnt_z;
      end
   end

   assign pins_o  = pins_reg;
   assign rdata_o = rdata_reg;
   assign done_o  = done_reg;

endmodule

/* rtl/flash_host.sv */
// module: host controller issuing reads, commands and sequences to a parallel flash
`timescale 1ns/1ps
module flash_host (
   input  wire logic                                clk_i,
   input  wire logic                                rst_i,
   // user request side
   input  wire logic                                req_valid_i,  // request strobe
   output logic                                     req_ready_o,  // idle, may take request
   input  wire flash_host_pkg::req_t                req_i,        // kind, address, data
   output logic                                     rsp_valid_o,  // one-cycle completion
   output logic [flash_host_pkg::DATA_W-1:0]        rsp_data_o,   // read data
   output logic                                     bypass_o,     // bypass mode active
   output logic                                     busy_o,       // device busy, synced
   // flash pins
   output logic                                     ce_n_o,
   output logic                                     oe_n_o,
   output logic                                     we_n_o,
   output logic                                     reset_n_o,
   output logic [flash_host_pkg::ADDR_W-1:0]        byte_address_o,
   output logic [flash_host_pkg::DATA_W-1:0]        data_bus_o,
   output logic                                     data_bus_oe_o,
   input  wire logic [flash_host_pkg::DATA_W-1:0]   data_bus_i,
   input  wire logic                                ready_busy_out_i
);

   // *****************************************
   // pin synchronisers
   // *****************************************
   logic [flash_host_pkg::DATA_W-1:0] dq_s1_reg, dq_s2_reg;   // data bus sync
   logic                              rb_s1_reg, rb_s2_reg;   // ready/busy sync

   // two-flop sync of device inputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dq_s1_reg <= '0;
         dq_s2_reg <= '0;
         rb_s1_reg <= 1'b1;
         rb_s2_reg <= 1'b1;
      end else begin
         dq_s1_reg <= data_bus_i;
         dq_s2_reg <= dq_s1_reg;
         rb_s1_reg <= ready_busy_out_i;
         rb_s2_reg <= rb_s1_reg;
      end
   end

   // *****************************************
   // sequencer
   // *****************************************
   typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT, SQ_DONE} sq_state_t;

   sq_state_t                           sq_reg, sq_next;        // sequencer state
   flash_host_pkg::req_t                req_reg;                // latched request
   logic [2:0]                          step_reg, step_next;    // cycle within sequence
   logic                                bypass_reg, bypass_next;// bypass mode flag
   logic                                standby_reg;            // chip idle since last cycle
   logic [flash_host_pkg::DATA_W-1:0]   rsp_data_reg;           // returned data
   logic                                rsp_valid_reg;          // completion pulse

   // per-step cycle descriptor
   logic [1:0]                          cy_kind;                // 0 read 1 write 2 reset
   logic [flash_host_pkg::ADDR_W-1:0]   cy_addr;
   logic [flash_host_pkg::DATA_W-1:0]   cy_data;
   logic [2:0]                          cy_last;                // index of final step
   logic                                cy_start;
   logic                                cy_done;
   logic [flash_host_pkg::DATA_W-1:0]   cy_rdata;
   flash_host_pkg::pins_t               pins;

   // named decodes
   wire  take      = req_valid_i & (sq_reg == SQ_IDLE);
   wire  dev_busy  = ~rb_s2_reg;
   wire  bp_prog   = bypass_reg & (req_reg.op == flash_host_pkg::OP_PROGRAM);
   wire  bp_leave  = bypass_reg & (req_reg.op == flash_host_pkg::OP_BYPASS);
   wire  last_step = (step_reg == cy_last);

   // step table for each sequence
   always_comb begin
      cy_kind = 2'h1;
      cy_addr = flash_host_pkg::UNLOCK_ADDR1;
      cy_data = flash_host_pkg::UNLOCK_DATA1;
      cy_last = 3'h2;
      case (req_reg.op)
         flash_host_pkg::OP_READ: begin
            // array, identification or status data, all plain reads
            cy_kind = 2'h0;
            cy_addr = req_reg.addr;
            cy_last = 3'h0;
         end
         flash_host_pkg::OP_WRITE: begin
            cy_addr = req_reg.addr;
            cy_data = req_reg.data;
            cy_last = 3'h0;
         end
         flash_host_pkg::OP_RESET_PIN: begin
            cy_kind = 2'h2;
            cy_last = 3'h0;
         end
         default: begin
            // sequences: two unlock cycles, command, then extras; bypass program and exit are two bare cycles
            cy_last = (req_reg.op == flash_host_pkg::OP_PROGRAM) ? 3'h3 :
                      (req_reg.op == flash_host_pkg::OP_AUTOSELECT ||
                       req_reg.op == flash_host_pkg::OP_BYPASS) ? 3'h2 : 3'h5;
            if (bp_prog || bp_leave) begin
               cy_last = 3'h1;
            end
            case (step_reg)
               3'h0: begin
                  if (bp_prog) begin
                     cy_data = flash_host_pkg::CMD_PROGRAM;
                  end else if (bp_leave) begin
                     cy_data = flash_host_pkg::CMD_BYP_EX1;
                  end
               end
               3'h1: begin
                  cy_addr = flash_host_pkg::UNLOCK_ADDR2;
                  cy_data = flash_host_pkg::UNLOCK_DATA2;
                  if (bp_prog) begin
                     cy_addr = req_reg.addr;
                     cy_data = req_reg.data;
                  end else if (bp_leave) begin
                     cy_data = flash_host_pkg::CMD_BYP_EX2;
                  end
               end
               3'h2: begin
                  case (req_reg.op)
                     flash_host_pkg::OP_PROGRAM:    cy_data = flash_host_pkg::CMD_PROGRAM;
                     flash_host_pkg::OP_AUTOSELECT: cy_data = flash_host_pkg::CMD_AUTOSEL;
                     flash_host_pkg::OP_BYPASS:     cy_data = flash_host_pkg::CMD_BYPASS;
                     default:                       cy_data = flash_host_pkg::CMD_ERASE;
                  endcase
               end
               3'h3: begin
                  if (req_reg.op == flash_host_pkg::OP_PROGRAM) begin
                     cy_addr = req_reg.addr;
                     cy_data = req_reg.data;
                  end
               end
               3'h4: begin
                  cy_addr = flash_host_pkg::UNLOCK_ADDR2;
                  cy_data = flash_host_pkg::UNLOCK_DATA2;
               end
               default: begin
                  // sector address picks the sector, else whole array
                  if (req_reg.op == flash_host_pkg::OP_SECT_ERASE) begin
                     cy_addr = req_reg.addr;
                     cy_data = flash_host_pkg::CMD_SECT_ER;
                  end else begin
                     cy_data = flash_host_pkg::CMD_CHIP_ER;
                  end
               end
            endcase
         end
      endcase
   end

   assign cy_start = (sq_reg == SQ_ISSUE);

   // sequencer next state
   always_comb begin
      sq_next     = sq_reg;
      step_next   = step_reg;
      bypass_next = bypass_reg;
      case (sq_reg)
         SQ_IDLE: begin
            if (take) begin
               sq_next   = SQ_ISSUE;
               step_next = 3'h0;
            end
         end
         SQ_ISSUE: sq_next = SQ_WAIT;
         SQ_WAIT: begin
            if (cy_done) begin
               if (last_step) begin
                  sq_next = SQ_DONE;
                  if (req_reg.op == flash_host_pkg::OP_BYPASS) begin
                     bypass_next = ~bypass_reg;
                  end
                  if (req_reg.op == flash_host_pkg::OP_RESET_PIN) begin
                     bypass_next = 1'b0;
                  end
               end else begin
                  sq_next   = SQ_ISSUE;
                  step_next = step_reg + 3'h1;
               end
            end
         end
         SQ_DONE: sq_next = SQ_IDLE;
         default: sq_next = SQ_IDLE;
      endcase
   end

   // sequencer registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sq_reg        <= SQ_IDLE;
         req_reg       <= '0;
         step_reg      <= 3'h0;
         bypass_reg    <= 1'b0;
         standby_reg   <= 1'b1;
         rsp_data_reg  <= '0;
         rsp_valid_reg <= 1'b0;
      end else begin
         sq_reg        <= sq_next;
         step_reg      <= step_next;
         bypass_reg    <= bypass_next;
         rsp_valid_reg <= (sq_reg == SQ_WAIT) && cy_done && last_step;
         if (take) begin
            req_reg <= req_i;
         end
         // any cycle ends with chip deselected, so next read pays select time
         if (cy_start | cy_done) begin
            standby_reg <= cy_done;
         end
         if (cy_done && cy_kind == 2'h0) begin
            rsp_data_reg <= cy_rdata;
         end
      end
   end

   // *****************************************
   // bus cycle engine
   // *****************************************
   flash_bus_cycle u_cycle (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .start_i   (cy_start),
      .kind_i    (cy_kind),
      .addr_i    (cy_addr),
      .data_i    (cy_data),
      .data_in_i (dq_s2_reg),
      .standby_i (standby_reg),
      .pins_o    (pins),
      .rdata_o   (cy_rdata),
      .done_o    (cy_done)
   );

   // outputs
   assign req_ready_o    = (sq_reg == SQ_IDLE);
   assign rsp_valid_o    = rsp_valid_reg;
   assign rsp_data_o     = rsp_data_reg;
   assign bypass_o       = bypass_reg;
   assign busy_o         = dev_busy;
   assign ce_n_o         = pins.ce_n;
   assign oe_n_o         = pins.oe_n;
   assign we_n_o         = pins.we_n;
   assign reset_n_o      = pins.reset_n;
   assign byte_address_o = pins.byte_address;
   assign data_bus_o     = pins.data_bus_out;
   assign data_bus_oe_o  = pins.data_bus_oe;

endmodule

/* bench/flash_host_chk.sv */
// checker: pin protocol assertions for the flash host controller
`timescale 1ns/1ps
module flash_host_chk (
   input wire logic                              clk_i,
   input wire logic                              rst_i,
   input wire logic                              req_ready_o,
   input wire logic                              rsp_valid_o,
   input wire logic                              busy_o,
   input wire logic                              ce_n_o,
   input wire logic                              oe_n_o,
   input wire logic                              we_n_o,
   input wire logic                              reset_n_o,
   input wire logic [flash_host_pkg::ADDR_W-1:0] byte_address_o,
   input wire logic                              data_bus_oe_o,
   input wire logic                              ready_busy_out_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] low_cnt; // cycles with the reset pin held low
   // count reset pin low time, saturating
   always_ff @(posedge clk_i)
      if (rst_i || reset_n_o) low_cnt <= 8'h00;
      else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
   sequence s_read_open;
      $fell(oe_n_o) && !ce_n_o;
   endsequence
   sequence s_read_hold;
      (!oe_n_o && !ce_n_o)[*4];
   endsequence
   a_write_selects: assert property (!we_n_o |-> oe_n_o && !ce_n_o && reset_n_o)
      else $error("write strobe with wrong selects");
   a_write_drives: assert property (!we_n_o |-> data_bus_oe_o)
      else $error("write strobe without data driven");
   a_read_clean: assert property (!oe_n_o |-> we_n_o && reset_n_o && !data_bus_oe_o)
      else $error("read with wrong controls or contention");
   a_read_access: assert property (s_read_open |-> s_read_hold)
      else $error("read cut shorter than access time");
   a_addr_steady: assert property (!ce_n_o && !$past(ce_n_o) |-> $stable(byte_address_o))
      else $error("address moved while selected");
   a_data_past_rise: assert property ($rose(we_n_o) |-> data_bus_oe_o)
      else $error("data released at write strobe rise");
   a_reset_width: assert property ($rose(reset_n_o) |-> low_cnt >= 8'h19)
      else $error("reset pulse too short");
   a_busy_follows: assert property (!ready_busy_out_i[*4] |-> busy_o)
      else $error("busy not reported");
   a_idle_follows: assert property (ready_busy_out_i[*4] |-> !busy_o)
      else $error("busy stuck after ready");
   a_ready_after: assert property (rsp_valid_o |=> req_ready_o)
      else $error("not ready after response");
endmodule
bind flash_host flash_host_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .req_ready_o(req_ready_o),
   .rsp_valid_o(rsp_valid_o), .busy_o(busy_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o),
   .we_n_o(we_n_o), .reset_n_o(reset_n_o), .byte_address_o(byte_address_o),
   .data_bus_oe_o(data_bus_oe_o), .ready_busy_out_i(ready_busy_out_i));

/* bench/flash_dev_model.sv */
// model: behavioural parallel flash device on the host pins
`timescale 1ns/1ps
module flash_dev_model #(
   parameter int         BUSY_CYC = 60,   // embedded operation length in cycles
   parameter logic [7:0] ID_CODE  = 8'h3C // arbitrary identification value
) (
   input  wire logic        clk_i,
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic        reset_n_i,
   input  wire logic [20:0] addr_i,
   input  wire logic [7:0]  host_data_i,
   input  wire logic        host_oe_i,
   output logic      [7:0]  data_o,
   output logic             ready_busy_o
);
   logic [7:0]  mem [256];           // small array image
   logic [7:0]  last_bus = 8'h00;    // wire level last cycle
   logic [7:0]  prev_wr  = 8'h00;    // previous command byte
   logic [7:0]  prog_val = 8'h00;    // byte under program
   logic [20:0] wr_addr  = '0;       // latched write address
   logic        id_mode  = 1'b0;
   logic        bypass   = 1'b0;
   logic        erase_on = 1'b0;
   int          busy_cnt = 0;
   wire         wr_n  = we_n_i | ce_n_i;                  // combined write strobe
   wire         drive = !ce_n_i && !oe_n_i && reset_n_i;
   wire [7:0]   dout  = (busy_cnt != 0) ? {~prog_val[7], 7'h00} :
                        id_mode ? ID_CODE : mem[addr_i[7:0]];
   // released wire shows a changing pattern, never a stale byte
   assign data_o = host_oe_i ? host_data_i : drive ? dout : ~last_bus;
   assign ready_busy_o = (busy_cnt == 0);
   initial foreach (mem[i]) mem[i] = 8'hFF;
   // embedded operation keeps running when deselected
   always @(posedge clk_i) begin
      last_bus <= data_o;
      if (!reset_n_i) busy_cnt <= 0;
      else if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
   end
   // reset pin returns to array read
   always @(negedge reset_n_i) begin
      id_mode = 1'b0;
      bypass = 1'b0;
      erase_on = 1'b0;
   end
   always @(negedge wr_n) #1 wr_addr = addr_i;
   // command latch and decode at write strobe rise
   always @(posedge wr_n) begin
      if (reset_n_i && busy_cnt == 0) begin
         if (prev_wr == 8'hA0) begin
            mem[wr_addr[7:0]] = mem[wr_addr[7:0]] & host_data_i;
            prog_val = host_data_i;
            busy_cnt = BUSY_CYC;
         end else if (erase_on && (host_data_i == 8'h30 || host_data_i == 8'h10)) begin
            foreach (mem[i]) mem[i] = 8'hFF;
            prog_val = 8'hFF;
            erase_on = 1'b0;
            busy_cnt = BUSY_CYC;
         end
         else if (host_data_i == 8'h80) erase_on = 1'b1;
         else if (host_data_i == 8'h20 && prev_wr == 8'h55) bypass = 1'b1;
         else if (host_data_i == 8'h00 && prev_wr == 8'h90) bypass = 1'b0;
         else if (host_data_i == 8'h90 && prev_wr == 8'h55 && !bypass) id_mode = 1'b1;
         else if (host_data_i == 8'hF0) id_mode = 1'b0;
      end
      prev_wr = host_data_i;
   end
endmodule

/* bench/flash_host_test.sv */
// testbench: flash host controller against the device model
`timescale 1ns/1ps
module flash_host_test;
   localparam logic [7:0] ID = 8'h3C; // arbitrary identification value
   logic clk_i, rst_i, req_valid, req_ready, rsp_valid, bypass, busy;
   logic ce_n, oe_n, we_n, reset_n, dq_oe, rdy;
   logic [20:0] addr;
   logic [7:0]  rsp_data, dq_out, dq_in, rdata;
   flash_host_pkg::req_t req;
   int errors = 0;
   int checked = 0;
   int wr_cnt = 0; // write strobes seen on the pins
   flash_host u_dut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid),
      .req_ready_o(req_ready), .req_i(req), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
      .bypass_o(bypass), .busy_o(busy), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n),
      .reset_n_o(reset_n), .byte_address_o(addr), .data_bus_o(dq_out),
      .data_bus_oe_o(dq_oe), .data_bus_i(dq_in), .ready_busy_out_i(rdy));
   flash_dev_model #(.ID_CODE(ID)) u_dev (.clk_i(clk_i), .ce_n_i(ce_n), .oe_n_i(oe_n),
      .we_n_i(we_n), .reset_n_i(reset_n), .addr_i(addr), .host_data_i(dq_out),
      .host_oe_i(dq_oe), .data_o(dq_in), .ready_busy_o(rdy));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   always @(negedge we_n) wr_cnt++;
   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one request, wait for its response
   task automatic do_req(input flash_host_pkg::op_t op, input logic [20:0] a,
                         input logic [7:0] d);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req <= '{op: op, addr: a, data: d};
      @(posedge clk_i);
      req_valid <= 1'b0;
      while (rsp_valid !== 1'b1 && n < 2000) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 2000) errors++;
      rdata = rsp_data;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [20:0] a, input logic [7:0] exp);
      do_req(flash_host_pkg::OP_READ, a, 8'h00);
      chk("read data", exp, rdata);
   endtask
   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (busy !== lvl && n < 300) begin
         @(negedge clk_i);
         n++;
      end
      chk("busy", {7'h00, lvl}, {7'h00, busy});
      @(posedge clk_i);
   endtask
   task automatic t_program;
      rd(21'h000010, 8'hFF);
      wr_cnt = 0;
      do_req(flash_host_pkg::OP_PROGRAM, 21'h000010, 8'h5A);
      chk("program writes", 8'h04, wr_cnt[7:0]);
      wait_busy(1'b1);
      rd(21'h000010, 8'h80);
      wait_busy(1'b0);
      rd(21'h000010, 8'h5A);
   endtask
   task automatic t_autoselect;
      do_req(flash_host_pkg::OP_AUTOSELECT, 21'h000000, 8'h00);
      rd(21'h000001, ID);
      do_req(flash_host_pkg::OP_WRITE, 21'h000000, flash_host_pkg::CMD_RESET);
      rd(21'h000010, 8'h5A);
   endtask
   task automatic t_bypass;
      do_req(flash_host_pkg::OP_BYPASS, 21'h000000, 8'h00);
      chk("bypass on", 8'h01, {7'h00, bypass});
      wr_cnt = 0;
      do_req(flash_host_pkg::OP_PROGRAM, 21'h000020, 8'h33);
      chk("bypass writes", 8'h02, wr_cnt[7:0]);
      wait_busy(1'b1);
      wait_busy(1'b0);
      rd(21'h000020, 8'h33);
      do_req(flash_host_pkg::OP_BYPASS, 21'h000000, 8'h00);
      chk("bypass off", 8'h00, {7'h00, bypass});
   endtask
   task automatic t_erase(input flash_host_pkg::op_t op);
      wr_cnt = 0;
      do_req(op, 21'h000010, 8'h00);
      chk("erase writes", 8'h06, wr_cnt[7:0]);
      wait_busy(1'b1);
      wait_busy(1'b0);
      rd(21'h000020, 8'hFF);
      do_req(flash_host_pkg::OP_PROGRAM, 21'h000020, 8'h33);
      wait_busy(1'b1);
      wait_busy(1'b0);
   endtask
   task automatic t_reset_abort;
      do_req(flash_host_pkg::OP_BYPASS, 21'h000000, 8'h00);
      do_req(flash_host_pkg::OP_PROGRAM, 21'h000030, 8'h0F);
      do_req(flash_host_pkg::OP_RESET_PIN, 21'h000000, 8'h00);
      chk("busy after reset", 8'h00, {7'h00, busy});
      chk("bypass after reset", 8'h00, {7'h00, bypass});
      rd(21'h000020, 8'h33);
   endtask
   initial begin
      rst_i = 1'b1;
      req_valid = 1'b0;
      req = '0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_program();
      t_autoselect();
      t_bypass();
      t_erase(flash_host_pkg::OP_SECT_ERASE);
      t_erase(flash_host_pkg::OP_CHIP_ERASE);
      t_reset_abort();
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      tally_and_finish();
   end
endmodule
